// ### stmc_compare.sv
// comparator A, comparator P and duty comparisons
module stmc_compare import stmc_pkg::*; (
    // counter and compare values
    input wire logic [15:0] cnt,
    input wire logic [15:0] cmp_a,
    input wire logic [7:0] cmp_p,
    // results
    output logic [15:0] cnt_inc,
    output logic hit_a,
    output logic hit_p,
    output logic duty_a,
    output logic duty_p
);
    assign cnt_inc = cnt + 16'h0001;
    // a zero value matches at the wrap to zero, i.e. overflow
    assign hit_p = (cnt_inc[15:8] == cmp_p) && (cnt_inc[7:0] == ZERO_BYTE);
    // a zero comparator A value never matches
    assign hit_a = (cnt_inc == cmp_a) && (cmp_a != RST_WORD);
    // duty at or above the period gives a full active level
    assign duty_a = (cnt < cmp_a);
    assign duty_p = (cmp_p == ZERO_BYTE) || (cnt[15:8] < cmp_p);
endmodule // stmc_compare

// ### stmc_pkg.sv
// constants shared by the standard timer block
package stmc_pkg;
    // register offsets on the byte-wide register port
    localparam logic [2:0] ADDR_CLOCK_CTRL = 3'h0;
    localparam logic [2:0] ADDR_MODE_PIN = 3'h1;
    localparam logic [2:0] ADDR_CNT_LOW = 3'h2;
    localparam logic [2:0] ADDR_CNT_HIGH = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LOW = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HIGH = 3'h5;
    localparam logic [2:0] ADDR_CMPP = 3'h6;
    localparam logic [2:0] ADDR_FLAGS = 3'h7;

    // timer_clock_control fields
    localparam int BIT_PAUSE = 7;
    localparam int CKSEL_HI = 6;
    localparam int CKSEL_LO = 4;
    localparam int BIT_ON = 3;

    // timer_mode_pin_control fields
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int ACT_HI = 5;
    localparam int ACT_LO = 4;
    localparam int BIT_INIT = 3;
    localparam int BIT_INV = 2;
    localparam int BIT_SWAP = 1;
    localparam int BIT_CLRSRC = 0;

    // flag register fields
    localparam int BIT_FLAG_A = 0;
    localparam int BIT_FLAG_P = 1;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [2:0] RST_CKSEL = 3'h0;
    localparam logic [1:0] RST_MODE = 2'h0;

    // operating modes
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_UNDEF = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    // pin actions
    localparam logic [1:0] ACT_00 = 2'h0;
    localparam logic [1:0] ACT_01 = 2'h1;
    localparam logic [1:0] ACT_10 = 2'h2;
    localparam logic [1:0] ACT_11 = 2'h3;

    // clock select codes
    localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H_DIV16 = 3'h2;
    localparam logic [2:0] CK_H_DIV64 = 3'h3;
    localparam logic [2:0] CK_SUB_A = 3'h4;
    localparam logic [2:0] CK_SUB_B = 3'h5;

    // prescaler terminal counts
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV16_MASK = 6'h0F;
    localparam logic [5:0] DIV64_MASK = 6'h3F;
    localparam logic [5:0] DIV_ONE = 6'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### stmc_prescale.sv
// timer clock tick generator selected by the clock-select field
module stmc_prescale import stmc_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // selection and sub clock tick
    input wire logic [2:0] clk_sel,
    input wire logic sub_tick,
    // one-cycle timer tick
    output logic tick
);
    logic [5:0] div_reg;
    logic tick_next;

    // free-running divider; the high clock is taken to be the system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + DIV_ONE;
        end
    end

    always_comb begin
        tick_next = 1'b0;
        case (clk_sel)
            CK_SYS_DIV4: tick_next = (div_reg[1:0] == DIV4_MASK[1:0]);
            CK_SYS: tick_next = 1'b1;
            CK_H_DIV16: tick_next = (div_reg[3:0] == DIV16_MASK[3:0]);
            CK_H_DIV64: tick_next = (div_reg == DIV64_MASK);
            CK_SUB_A, CK_SUB_B: tick_next = sub_tick;
            default: tick_next = 1'b0; // undefined codes stop the counter
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= tick_next;
        end
    end
endmodule // stmc_prescale

// ### stmc_timer.sv
// standard 16-bit timer with compare, pwm and single pulse output
// Functional notes
// - mode field: 00 compare, 10 pwm or single pulse, 11 timer
// - in timer mode the output pin is not driven
// - compare mode A match: keep, drive low, drive high or toggle
// - pwm modes: force inactive, force active, pwm, single pulse
// - in compare mode, rising counter_on returns the pin to its initial level
// - compare mode initial level bit sets the pre-match pin level
// - pwm initial level bit sets active polarity
// - single pulse level on counter_on rise comes from initial bit
// - initial and invert bits do nothing in timer mode
// - invert bit inverts the output pin
// - swap bit exchanges period and duty roles of the compare values
// - clear source: A match, or else P match or overflow
// - overflow clearing only with zero P value, counter wraps
// - clear source ignored in pwm and single pulse modes
// - counter readable as two zero-reset read-only bytes
// - comparator A value held in two zero-reset writable bytes
// - P value against top byte, period n*256 or 65536 clocks
// - three low bits of clock control read as zero
// - counter_on rise clears and starts, fall stops and holds
// - matches set A and P flags, no P flag in single pulse mode or with A clearing in compare and timer modes
// - clock select field chooses the timer clock source
// - pause holds the counter, clearing it resumes counting
module stmc_timer import stmc_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // sub clock tick, synchronous single-cycle pulse
    input wire logic sub_clk_tick,
    // output pin
    output logic timer_out_pin,
    output logic timer_out_en,
    // match flags
    output logic match_a_flag,
    output logic match_p_flag
);
    logic rst_meta_reg;
    logic rst_n_sync;
    logic counter_pause;
    logic [2:0] clock_source_sel;
    logic counter_on;
    logic on_prev_reg;
    logic [1:0] op_mode_sel;
    logic [1:0] pin_action_sel;
    logic out_initial_level;
    logic out_invert;
    logic duty_period_swap;
    logic clear_source_sel;
    logic [15:0] cnt_reg;
    logic [15:0] compare_a_value;
    logic [7:0] compare_p_value;
    logic level_reg;
    logic level_next;
    logic tick;
    logic [15:0] cnt_inc;
    logic hit_a;
    logic hit_p;
    logic duty_a;
    logic duty_p;
    logic on_rise;
    logic run;
    logic pwm_family;
    logic single_pulse;
    logic clr;
    logic set_a;
    logic set_p;
    logic pwm_active;
    logic wr_ctrl0;
    logic wr_flags;

    // reset release through two flops; assertion is immediate
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    stmc_prescale u_prescale (
        .clk(mclk),
        .rst_n(rst_n_sync),
        .clk_sel(clock_source_sel),
        .sub_tick(sub_clk_tick),
        .tick(tick)
    );

    stmc_compare u_compare (
        .cnt(cnt_reg),
        .cmp_a(compare_a_value),
        .cmp_p(compare_p_value),
        .cnt_inc(cnt_inc),
        .hit_a(hit_a),
        .hit_p(hit_p),
        .duty_a(duty_a),
        .duty_p(duty_p)
    );

    // decoded control terms
    assign wr_ctrl0 = reg_wr && (reg_addr == ADDR_CLOCK_CTRL);
    assign wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);
    assign on_rise = counter_on && !on_prev_reg;
    assign run = tick && counter_on && !counter_pause && !on_rise;
    assign pwm_family = (op_mode_sel == MODE_PWM);
    assign single_pulse = pwm_family && (pin_action_sel == ACT_11);

    // counter clear choice per mode
    always_comb begin
        if (single_pulse) begin
            clr = 1'b0; // single pulse stops by dropping counter_on instead
        end else if (pwm_family) begin
            clr = duty_period_swap ? hit_a : hit_p;
        end else begin
            clr = clear_source_sel ? hit_a : hit_p;
        end
    end

    assign set_a = run && hit_a;
    assign set_p = run && hit_p && !single_pulse && (pwm_family || !clear_source_sel);

    assign pwm_active = duty_period_swap ? duty_p : duty_a;

    // clock control register; hardware clears counter_on at the end of a pulse
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            counter_pause <= 1'b0;
            clock_source_sel <= RST_CKSEL;
            counter_on <= 1'b0;
        end else if (wr_ctrl0) begin
            counter_pause <= reg_wdata[BIT_PAUSE];
            clock_source_sel <= reg_wdata[CKSEL_HI:CKSEL_LO];
            counter_on <= reg_wdata[BIT_ON];
        end else if (single_pulse && set_a) begin
            counter_on <= 1'b0;
        end
    end

    // edge detector for counter_on
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= counter_on;
        end
    end

    // mode and pin control register
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            op_mode_sel <= RST_MODE;
            pin_action_sel <= ACT_00;
            out_initial_level <= 1'b0;
            out_invert <= 1'b0;
            duty_period_swap <= 1'b0;
            clear_source_sel <= 1'b0;
        end else if (reg_wr && (reg_addr == ADDR_MODE_PIN)) begin
            op_mode_sel <= reg_wdata[MODE_HI:MODE_LO];
            pin_action_sel <= reg_wdata[ACT_HI:ACT_LO];
            out_initial_level <= reg_wdata[BIT_INIT];
            out_invert <= reg_wdata[BIT_INV];
            duty_period_swap <= reg_wdata[BIT_SWAP];
            clear_source_sel <= reg_wdata[BIT_CLRSRC];
        end
    end

    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            compare_a_value <= RST_WORD;
        end else if (reg_wr && (reg_addr == ADDR_CMPA_LOW)) begin
            compare_a_value[7:0] <= reg_wdata;
        end else if (reg_wr && (reg_addr == ADDR_CMPA_HIGH)) begin
            compare_a_value[15:8] <= reg_wdata;
        end
    end

    // comparator P value
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            compare_p_value <= RST_BYTE;
        end else if (reg_wr && (reg_addr == ADDR_CMPP)) begin
            compare_p_value <= reg_wdata;
        end
    end

    // clear on start, hold while off
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cnt_reg <= RST_WORD;
        end else if (on_rise) begin
            cnt_reg <= RST_WORD;
        end else if (run) begin
            cnt_reg <= clr ? RST_WORD : cnt_inc;
        end
    end

    // match flags: write one to clear, a set in the same cycle wins
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end else begin
            match_a_flag <= set_a || (match_a_flag && !(wr_flags && reg_wdata[BIT_FLAG_A]));
            match_p_flag <= set_p || (match_p_flag && !(wr_flags && reg_wdata[BIT_FLAG_P]));
        end
    end

    // internal mode output before inversion
    always_comb begin
        level_next = level_reg;
        case (op_mode_sel)
            MODE_CMP: begin
                if (on_rise) begin
                    level_next = out_initial_level;
                end else if (set_a) begin
                    case (pin_action_sel)
                        ACT_01: level_next = 1'b0;
                        ACT_10: level_next = 1'b1;
                        ACT_11: level_next = !level_reg;
                        default: level_next = level_reg;
                    endcase
                end
            end
            MODE_PWM: begin
                // initial bit is the active level
                case (pin_action_sel)
                    ACT_00: level_next = !out_initial_level;
                    ACT_01: level_next = out_initial_level;
                    ACT_10: level_next = pwm_active ? out_initial_level : !out_initial_level;
                    // pulse active while counter_on stays high
                    default: level_next = counter_on ? out_initial_level : !out_initial_level;
                endcase
            end
            // timer and undefined modes leave the level alone
            default: level_next = level_reg;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
        end
    end

    // pin flops; the pin is released in timer and undefined modes
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            timer_out_pin <= 1'b0;
            timer_out_en <= 1'b0;
        end else begin
            timer_out_en <= (op_mode_sel == MODE_CMP) || pwm_family;
            if ((op_mode_sel == MODE_CMP) || pwm_family) begin
                timer_out_pin <= level_next ^ out_invert;
            end
        end
    end

    // registered read data, valid the cycle after the read strobe
    always_ff @(posedge mclk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            reg_rdata <= RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_CLOCK_CTRL) begin
                reg_rdata <= {counter_pause, clock_source_sel, counter_on, 3'h0};
            end else if (reg_addr == ADDR_MODE_PIN) begin
                reg_rdata <= {op_mode_sel, pin_action_sel, out_initial_level, out_invert,
                              duty_period_swap, clear_source_sel};
            end else if (reg_addr == ADDR_CNT_LOW) begin
                reg_rdata <= cnt_reg[7:0];
            end else if (reg_addr == ADDR_CNT_HIGH) begin
                reg_rdata <= cnt_reg[15:8];
            end else if (reg_addr == ADDR_CMPA_LOW) begin
                reg_rdata <= compare_a_value[7:0];
            end else if (reg_addr == ADDR_CMPA_HIGH) begin
                reg_rdata <= compare_a_value[15:8];
            end else if (reg_addr == ADDR_CMPP) begin
                reg_rdata <= compare_p_value;
            end else begin
                reg_rdata <= {6'h00, match_p_flag, match_a_flag};
            end
        end
    end

    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_sync);

    sequence s_pulse_end;
        !counter_on ##1 (timer_out_pin == $past(!out_initial_level ^ out_invert));
    endsequence

    a_start_clears_cnt: assert property (on_rise |=> cnt_reg == RST_WORD)
        else $error("counter not cleared on start");
    a_off_holds_cnt: assert property (!counter_on |=> $stable(cnt_reg))
        else $error("counter moved while off");
    a_pause_holds_cnt: assert property (counter_pause && !on_rise |=> $stable(cnt_reg))
        else $error("counter moved while paused");
    a_timer_pin_released: assert property (op_mode_sel == MODE_TIMER |=> !timer_out_en)
        else $error("pin driven in timer mode");
    a_cmp_start_level: assert property (on_rise && op_mode_sel == MODE_CMP
        |=> timer_out_pin == $past(out_initial_level ^ out_invert))
        else $error("pin not at initial level after start");
    a_force_inactive: assert property (pwm_family && pin_action_sel == ACT_00
        |=> timer_out_pin == $past(!out_initial_level ^ out_invert))
        else $error("forced inactive level wrong");
    a_flag_a_set: assert property (set_a |=> match_a_flag)
        else $error("A match flag not set");
    a_no_p_flag: assert property (!pwm_family && clear_source_sel && !match_p_flag
        |=> !match_p_flag)
        else $error("P flag set while A clears");
    a_clear_on_a: assert property (run && hit_a && clear_source_sel && op_mode_sel == MODE_CMP
        |=> cnt_reg == RST_WORD)
        else $error("counter not cleared on A match");
    a_pulse_ends: assert property (run && single_pulse && hit_a && !wr_ctrl0 |=> s_pulse_end)
        else $error("single pulse did not end on A match");
    a_ctrl_low_zero: assert property (reg_rd && reg_addr == ADDR_CLOCK_CTRL
        |=> reg_rdata[2:0] == 3'h0)
        else $error("unused control bits not zero");
endmodule // stmc_timer

// ### test_standard_timer_module_control.sv
// self-checking testbench for the standard timer block
module test_standard_timer_module_control import stmc_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

    // design ports
    logic mclk;
    logic reset_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic sub_clk_tick;
    logic timer_out_pin;
    logic timer_out_en;
    logic match_a_flag;
    logic match_p_flag;
    int error_cnt = 0;
    int comparisons = 0;
    logic [7:0] v1, v2, v3;
    logic exp_pin;
    int high_cnt;
    // clock control values and counts for 64 running cycles: div4, div16, div64, sub clock
    logic [7:0] ck_ctrl [4] = '{8'h08, 8'h28, 8'h38, 8'h48};
    logic [7:0] ck_exp [4] = '{8'h10, 8'h04, 8'h01, 8'h20};

    stmc_timer dut (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sub_clk_tick(sub_clk_tick),
        .timer_out_pin(timer_out_pin), .timer_out_en(timer_out_en),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
    );

    // 20 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // sub clock tick on every other system clock, so a sub clock count is exact
    initial begin
        sub_clk_tick = 1'b0;
        forever begin
            @(posedge mclk);
            sub_clk_tick <= ~sub_clk_tick;
        end
    end

    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data sampled in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    // bounded wait for a match flag; sel 0 waits for A, 1 for P
    task automatic wait_flag(input bit sel);
        int n;
        n = 0;
        while (((sel ? match_p_flag : match_a_flag) !== 1'b1) && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000) begin
            error_cnt++;
            $display("flag wait expired t=%0t", $time);
        end
    endtask

    // stop, configure, clear flags, start with the system clock selected
    task automatic start(input logic [7:0] ctrl1, input logic [15:0] a, input logic [7:0] p);
        wr(ADDR_CLOCK_CTRL, 8'h10);
        wr(ADDR_MODE_PIN, ctrl1);
        wr(ADDR_CMPA_LOW, a[7:0]);
        wr(ADDR_CMPA_HIGH, a[15:8]);
        wr(ADDR_CMPP, p);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CLOCK_CTRL, 8'h18);
        // on-edge is seen next cycle, pin settles one edge later
        repeat (3) @(negedge mclk);
    endtask

    task automatic end_sim();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog sized above the expected run of about 74000 cycles, most of it the full wrap
    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        reset_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        // register reset values
        for (int a = 0; a < 7; a++) begin
            rd(3'(a), v1);
            `CHK(v1, 8'h00)
        end
        // unused control bits read zero
        wr(ADDR_CLOCK_CTRL, 8'hFF);
        rd(ADDR_CLOCK_CTRL, v1);
        `CHK(v1, 8'hF8)
        wr(ADDR_CLOCK_CTRL, 8'h00);
        // writable bytes read back, counter bytes ignore writes
        wr(ADDR_MODE_PIN, 8'h5A);
        wr(ADDR_CMPA_LOW, 8'hA5);
        wr(ADDR_CMPA_HIGH, 8'h3C);
        wr(ADDR_CMPP, 8'hC3);
        wr(ADDR_CNT_LOW, 8'h55);
        wr(ADDR_CNT_HIGH, 8'hAA);
        rd(ADDR_MODE_PIN, v1);
        `CHK(v1, 8'h5A)
        rd(ADDR_CMPA_LOW, v1);
        `CHK(v1, 8'hA5)
        rd(ADDR_CMPA_HIGH, v1);
        `CHK(v1, 8'h3C)
        rd(ADDR_CMPP, v1);
        `CHK(v1, 8'hC3)
        rd(ADDR_CNT_LOW, v1);
        `CHK(v1, 8'h00)
        rd(ADDR_CNT_HIGH, v1);
        `CHK(v1, 8'h00)
        // compare mode: every action, initial level and invert
        // an action equal to the initial level must leave the pin alone
        for (int k = 0; k < 16; k++) begin
            start({2'b00, 2'(k), k[2], k[3], 2'b01}, 16'h0100, 8'h00);
            `CHK(timer_out_en, 1'b1)
            `CHK(timer_out_pin, k[2] ^ k[3])
            wait_flag(1'b0);
            case (k[1:0])
                2'd0: exp_pin = k[2];
                2'd1: exp_pin = 1'b0;
                2'd2: exp_pin = 1'b1;
                default: exp_pin = ~k[2];
            endcase
            `CHK(timer_out_pin, exp_pin ^ k[3])
            `CHK(match_p_flag, 1'b0)
        end
        // single pulse: active level at start, A match ends pulse and stops
        for (int i = 0; i < 2; i++) begin
            start({4'hB, i[0], 3'b000}, 16'h0040, 8'h00);
            `CHK(timer_out_pin, i[0])
            wait_flag(1'b0);
            repeat (2) @(negedge mclk);
            `CHK(timer_out_pin, ~i[0])
            rd(ADDR_CLOCK_CTRL, v1);
            `CHK(v1, 8'h10)
        end
        // timer mode, clear on P: both flags, counter below one P period
        start(8'hCC, 16'h0080, 8'h01);
        `CHK(timer_out_en, 1'b0)
        wait_flag(1'b1);
        `CHK(match_a_flag, 1'b1)
        rd(ADDR_CNT_HIGH, v1);
        `CHK(v1, 8'h00)
        // pause holds the count, release resumes
        wr(ADDR_CLOCK_CTRL, 8'h98);
        rd(ADDR_CNT_LOW, v1);
        rd(ADDR_CNT_LOW, v2);
        `CHK(v2, v1)
        wr(ADDR_CLOCK_CTRL, 8'h18);
        rd(ADDR_CNT_LOW, v3);
        `CHK(v3 != v1, 1'b1)
        // stop keeps the count
        wr(ADDR_CLOCK_CTRL, 8'h10);
        rd(ADDR_CNT_LOW, v1);
        repeat (5) @(posedge mclk);
        rd(ADDR_CNT_LOW, v2);
        `CHK(v2, v1)
        // timer mode, clear on A: no P flag ever
        start(8'hC1, 16'h0080, 8'h01);
        wait_flag(1'b0);
        repeat (300) @(negedge mclk);
        `CHK(match_p_flag, 1'b0)
        rd(ADDR_CNT_HIGH, v1);
        `CHK(v1, 8'h00)
        // overflow clearing with zero P value wraps the counter
        start(8'hC0, 16'h0000, 8'h00);
        // run past the wrap at FFFF so the count has restarted from zero
        repeat (65540) @(negedge mclk);
        rd(ADDR_CNT_HIGH, v1);
        `CHK(v1, 8'h00)
        `CHK(match_p_flag, 1'b1)
        // pwm duty over one period: polarity, swap, invert, clear source
        for (int i = 0; i < 5; i++) begin
            case (i)
                0: start(8'hA8, 16'h0040, 8'h01);
                1: start(8'hA0, 16'h0040, 8'h01);
                2: start(8'hAA, 16'h0200, 8'h01);
                3: start(8'hAC, 16'h0040, 8'h01);
                default: start(8'hA9, 16'h0040, 8'h01);
            endcase
            high_cnt = 0;
            repeat ((i == 2) ? 512 : 256) begin
                @(negedge mclk);
                high_cnt += (timer_out_pin === 1'b1) ? 1 : 0;
            end
            case (i)
                0, 4: `CHK(high_cnt, 64)
                1, 3: `CHK(high_cnt, 192)
                default: `CHK(high_cnt, 256)
            endcase
        end
        // forced pwm levels: inactive then active, active high
        start(8'h88, 16'h0040, 8'h01);
        `CHK(timer_out_pin, 1'b0)
        start(8'h98, 16'h0040, 8'h01);
        `CHK(timer_out_pin, 1'b1)
        wr(ADDR_CLOCK_CTRL, 8'h10);
        wr(ADDR_MODE_PIN, 8'hC0);
        // ticks over 64 running cycles per clock source
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CLOCK_CTRL, ck_ctrl[i]);
            repeat (63) @(posedge mclk);
            wr(ADDR_CLOCK_CTRL, 8'h00);
            rd(ADDR_CNT_LOW, v1);
            `CHK(v1, ck_exp[i])
        end
        end_sim();
    end
endmodule // test_standard_timer_module_control
